// >>> src/instruction_sequence_control.sv
// Program-control sequencer: alternates instruction and data half cycles,
// moves words between program register, operation/address registers,
// distributor, drum storage and the card input buffer.
// Assumes drum timing on the same clock flags the addressed word as it passes.
//
// Notes on behaviour
// - The restart word before a D half cycle loads op and D-address straight from the program register.
// - In the D half cycle of codes other than no-op, stop, read and 24 the distributor takes the addressed word as it passes the heads.
// - After distributor read-in a restart to I loads the I-address and fetches from there.
// - Code 24 writes the distributor into the D-address location during the D half cycle.
// - A fetch from address 8000 takes the word from the storage-entry switches.
// - A read op whose card lacks the load punch ends with a normal restart to I.
// - Computer reset in run mode sets the address register to 8000.
// - The no-op code does nothing and restarts to I at its own I-address.
// - The stop code halts until program start is pressed again.
// - Transfer copies the address switches into the address register for the next start.
// - A card past the second station leaves its fields in the leading buffer words.
// - The read code copies the buffer into the band read-in words, then blanks the buffer.
// - A back signal after a load card flips to I without restart, keeping the D-address.
`timescale 1ns/1ps
module instruction_sequence_control
  import seq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  // Console switches and keys (pins)
  input  wire logic [seq_pkg::WORD_W-1:0] entry_sw_i,
  input  wire logic [seq_pkg::ADDR_W-1:0] addr_sw_i,
  input  wire logic                       run_mode_i,
  input  wire logic                       reset_key_i,
  input  wire logic                       transfer_key_i,
  input  wire logic                       start_key_i,
  // Card reader (pins)
  input  wire logic                       card_word_stb_i,
  input  wire logic [seq_pkg::SLOT_W-1:0] card_word_idx_i,
  input  wire logic [seq_pkg::WORD_W-1:0] card_word_i,
  input  wire logic                       card_load_punch_i,
  input  wire logic                       reader_back_i,
  output logic                            feed_req_o,
  // Drum storage (same clock)
  input  wire logic                       stor_word_pass_i,
  input  wire logic [seq_pkg::WORD_W-1:0] stor_rd_data_i,
  output logic [seq_pkg::ADDR_W-1:0]      stor_addr_o,
  output logic                            stor_readin_o,
  output logic [seq_pkg::SLOT_W-1:0]      stor_slot_o,
  output logic                            stor_wr_en_o,
  output logic [seq_pkg::WORD_W-1:0]      stor_wr_data_o,
  // Status
  output logic [seq_pkg::WORD_W-1:0]      prog_o,
  output logic [seq_pkg::WORD_W-1:0]      dist_o,
  output logic [seq_pkg::OP_W-1:0]        op_o,
  output logic                            halted_o
);

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------------
  logic                  rst_a_q;
  logic                  rst_n_q;
  logic [6:0]            keys_s;
  logic [6:0]            keys_prev_q;
  logic [WORD_W+ADDR_W-1:0] sw_s;
  logic [WORD_W+SLOT_W-1:0] card_s;

  // Reset is released through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  pin_sync #(.WIDTH(7)) u_keys_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_q),
    .ce_i      (ce_i),
    .pin_i     ({card_load_punch_i, card_word_stb_i, reader_back_i, start_key_i,
                 transfer_key_i, reset_key_i, run_mode_i}),
    .level_o   (keys_s)
  );

  pin_sync #(.WIDTH(WORD_W+ADDR_W)) u_sw_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_q),
    .ce_i      (ce_i),
    .pin_i     ({entry_sw_i, addr_sw_i}),
    .level_o   (sw_s)
  );

  // Card data must be steady before its strobe; both pass the same depth
  pin_sync #(.WIDTH(WORD_W+SLOT_W)) u_card_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_q),
    .ce_i      (ce_i),
    .pin_i     ({card_word_i, card_word_idx_i}),
    .level_o   (card_s)
  );

  logic                 run_mode;
  logic                 reset_pulse;
  logic                 transfer_pulse;
  logic                 start_pulse;
  logic                 back_pulse;
  logic                 card_stb_pulse;
  logic                 load_punch;
  logic [WORD_W-1:0]    entry_sw;
  logic [ADDR_W-1:0]    addr_sw;

  // Rising edges of the synchronised keys give one-cycle events
  assign run_mode       = keys_s[0];
  assign reset_pulse    = keys_s[1] & ~keys_prev_q[1];
  assign transfer_pulse = keys_s[2] & ~keys_prev_q[2];
  assign start_pulse    = keys_s[3] & ~keys_prev_q[3];
  assign back_pulse     = keys_s[4] & ~keys_prev_q[4];
  assign card_stb_pulse = keys_s[5] & ~keys_prev_q[5];
  assign load_punch     = keys_s[6];
  assign entry_sw       = sw_s[WORD_W+ADDR_W-1:ADDR_W];
  assign addr_sw        = sw_s[ADDR_W-1:0];

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      keys_prev_q <= 7'h00;
    end else if (ce_i) begin
      keys_prev_q <= keys_s;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer state and registers
  // ------------------------------------------------------------------
  seq_state_t           state_q;
  logic [WORD_W-1:0]    prog_q;
  logic [WORD_W-1:0]    dist_q;
  logic [OP_W-1:0]      op_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [SLOT_W-1:0]    slot_q;
  logic                 load_card_q;
  logic [WORD_W-1:0]    buf_q [BUF_WORDS];
  logic                 fetch_sw;
  logic                 xfer_done;

  assign fetch_sw  = (addr_q == ADDR_SWITCHES);
  assign xfer_done = (state_q == ST_RD_XFER) && stor_word_pass_i && (slot_q == SLOT_LAST);

  // Control commutator; the reset key overrides every state
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_HALT;
    end else if (ce_i) begin
      if (reset_pulse) begin
        state_q <= ST_HALT;                     // Next start begins in I
      end else begin
        case (state_q)
          ST_HALT:    if (start_pulse) state_q <= ST_I_HALF;
          ST_I_HALF:  if (fetch_sw || stor_word_pass_i) state_q <= ST_RST_D;
          ST_RST_D:   state_q <= ST_D_HALF;
          ST_D_HALF: begin
            case (op_q)
              OP_NOOP:  state_q <= ST_RST_I;
              OP_STOP:  state_q <= ST_HALT;
              OP_READ:  state_q <= ST_RD_XFER;
              default:  if (stor_word_pass_i) state_q <= ST_RST_I;
            endcase
          end
          ST_RD_XFER: if (xfer_done) state_q <= ST_RD_WAIT;
          ST_RD_WAIT: begin
            if (back_pulse) begin
              state_q <= load_card_q ? ST_I_HALF : ST_RST_I;
            end
          end
          ST_RST_I:   state_q <= ST_I_HALF;
          default:    state_q <= ST_HALT;
        endcase
      end
    end
  end

  // Operation and address registers
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_q   <= OP_RESET;
      addr_q <= ADDR_RESET;
    end else if (ce_i) begin
      if (reset_pulse) begin
        op_q <= OP_RESET;
        if (run_mode) addr_q <= ADDR_SWITCHES;
      end else if (transfer_pulse && state_q == ST_HALT) begin
        addr_q <= addr_sw;
      end else if (state_q == ST_RST_D) begin
        op_q   <= prog_q[OP_MSB:OP_LSB];
        addr_q <= prog_q[DA_MSB:DA_LSB];
      end else if (state_q == ST_RST_I) begin
        op_q   <= OP_RESET;
        addr_q <= prog_q[IA_MSB:IA_LSB];
      end
    end
  end

  // Program register and distributor
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prog_q <= WORD_BLANK;
      dist_q <= WORD_BLANK;
    end else if (ce_i) begin
      if (reset_pulse) begin
        prog_q <= WORD_BLANK;
        dist_q <= WORD_BLANK;
      end else if (state_q == ST_I_HALF) begin
        if (fetch_sw) begin
          prog_q <= entry_sw;
        end else if (stor_word_pass_i) begin
          prog_q <= stor_rd_data_i;
        end
      end else if (state_q == ST_D_HALF && stor_word_pass_i &&
                   op_q != OP_NOOP && op_q != OP_STOP &&
                   op_q != OP_READ && op_q != OP_STORE_DIST) begin
        dist_q <= stor_rd_data_i;
      end
    end
  end

  // Read buffer: filled by the reader, drained to storage, then blanked
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < BUF_WORDS; i++) buf_q[i] <= WORD_BLANK;
      slot_q <= '0;
    end else if (ce_i) begin
      if (state_q != ST_RD_XFER) begin
        slot_q <= '0;
      end else if (stor_word_pass_i) begin
        slot_q <= slot_q + 4'h1;
      end
      if (xfer_done) begin
        for (int i = 0; i < BUF_WORDS; i++) buf_q[i] <= WORD_BLANK;
      end else if (card_stb_pulse && card_s[SLOT_W-1:0] <= SLOT_LAST) begin
        buf_q[card_s[SLOT_W-1:0]] <= card_s[WORD_W+SLOT_W-1:SLOT_W];
      end
    end
  end

  // Load punch of the card last read; the back signal consumes it
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_card_q <= 1'b0;
    end else if (ce_i) begin
      if (card_stb_pulse) begin
        load_card_q <= load_punch;              // A new card wins over consumption
      end else if (back_pulse && state_q == ST_RD_WAIT) begin
        load_card_q <= 1'b0;
      end
    end
  end

  // Feed request pulses as the read op leaves its D half cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      feed_req_o <= 1'b0;
    end else if (ce_i) begin
      feed_req_o <= (state_q == ST_D_HALF) && (op_q == OP_READ);
    end
  end

  // ------------------------------------------------------------------
  // Storage side
  // ------------------------------------------------------------------
  // Address register selects the band; writes happen as the word passes
  assign stor_addr_o    = addr_q;
  assign stor_readin_o  = (state_q == ST_RD_XFER);
  assign stor_slot_o    = slot_q + SLOT_FIRST;
  assign stor_wr_en_o   = ce_i && stor_word_pass_i &&
                          ((state_q == ST_RD_XFER) ||
                           (state_q == ST_D_HALF && op_q == OP_STORE_DIST));
  assign stor_wr_data_o = (state_q == ST_RD_XFER) ? buf_q[slot_q] : dist_q;
  assign prog_o         = prog_q;
  assign dist_o         = dist_q;
  assign op_o           = op_q;
  assign halted_o       = (state_q == ST_HALT);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_restart_d;
    ce_i && !reset_pulse && state_q == ST_RST_D;
  endsequence

  sequence s_back_plain;
    ce_i && !reset_pulse && state_q == ST_RD_WAIT && back_pulse && !load_card_q;
  endsequence

  a_restart_d_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    s_restart_d |=> op_q == $past(prog_q[OP_MSB:OP_LSB]) &&
                    addr_q == $past(prog_q[DA_MSB:DA_LSB]) && state_q == ST_D_HALF)
    else $error("restart to D did not load op and D-address");

  a_dist_readin: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && !reset_pulse && state_q == ST_D_HALF && stor_word_pass_i && op_q == 8'h60)
    |=> dist_q == $past(stor_rd_data_i) ##1 (!ce_i || addr_q == $past(prog_q[IA_MSB:IA_LSB])))
    else $error("distributor read-in or restart to I wrong");

  a_restart_i_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && !reset_pulse && state_q == ST_RST_I)
    |=> addr_q == $past(prog_q[IA_MSB:IA_LSB]) && state_q == ST_I_HALF)
    else $error("restart to I did not load I-address");

  a_store_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && state_q == ST_D_HALF && op_q == OP_STORE_DIST && stor_word_pass_i)
    |-> stor_wr_en_o && stor_wr_data_o == dist_q && stor_addr_o == addr_q)
    else $error("store distributor write missing");

  a_switch_fetch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && !reset_pulse && state_q == ST_I_HALF && addr_q == ADDR_SWITCHES)
    |=> prog_q == $past(entry_sw) && state_q == ST_RST_D)
    else $error("fetch from 8000 did not use entry switches");

  a_plain_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    s_back_plain |=> state_q == ST_RST_I)
    else $error("non-load card did not restart to I");

  a_reset_8000: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && reset_pulse && run_mode) |=> addr_q == ADDR_SWITCHES && halted_o)
    else $error("computer reset in run mode did not set 8000");

  a_noop_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && !reset_pulse && state_q == ST_D_HALF && op_q == OP_NOOP)
    |-> !stor_wr_en_o ##1 state_q == ST_RST_I)
    else $error("no-op did not restart to I");

  a_stop_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (halted_o && !start_pulse) |=> halted_o)
    else $error("sequencer left halt without start");

  a_transfer_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && halted_o && transfer_pulse && !reset_pulse) |=> addr_q == $past(addr_sw))
    else $error("transfer key did not load address switches");

  a_buffer_erase: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && xfer_done) |=> buf_q[0] == WORD_BLANK && state_q == ST_RD_WAIT)
    else $error("read buffer not blanked after transfer");

  a_load_flip: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    (ce_i && !reset_pulse && state_q == ST_RD_WAIT && back_pulse && load_card_q)
    |=> state_q == ST_I_HALF && $stable(addr_q))
    else $error("load card back signal did not flip to I");

endmodule

// >>> src/pin_sync.sv
// Three-stage input synchroniser for pins from outside the clock domain.
// Assumes the input is steady for at least three clocks around a change.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // Pins in, filtered level out
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ------------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------------
  // The first stage is read only by the second; a bit moves once 2 and 3 agree
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_o <= '0;
    end else if (ce_i) begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
    end
  end

endmodule

// >>> src/seq_pkg.sv
// Constants for the instruction sequence controller: word layout, operation
// codes, special addresses and read buffer geometry.
// Assumes ten-digit BCD words and four-digit BCD addresses throughout.
package seq_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int WORD_W  = 40;            // Ten BCD digits
  localparam int ADDR_W  = 16;            // Four BCD digits
  localparam int OP_W    = 8;             // Two BCD digits
  localparam int OP_MSB  = 39;
  localparam int OP_LSB  = 32;
  localparam int DA_MSB  = 31;            // Data address field
  localparam int DA_LSB  = 16;
  localparam int IA_MSB  = 15;            // Instruction address field
  localparam int IA_LSB  = 0;

  // ------------------------------------------------------------------
  // Codes and addresses
  // ------------------------------------------------------------------
  localparam logic [OP_W-1:0]   OP_NOOP       = 8'h00;
  localparam logic [OP_W-1:0]   OP_STOP       = 8'h01;
  localparam logic [OP_W-1:0]   OP_STORE_DIST = 8'h24;
  localparam logic [OP_W-1:0]   OP_READ       = 8'h70;
  localparam logic [ADDR_W-1:0] ADDR_SWITCHES = 16'h8000;
  localparam logic [WORD_W-1:0] WORD_BLANK    = 40'h00_0000_0000;
  localparam logic [OP_W-1:0]   OP_RESET      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 16'h0000;

  // ------------------------------------------------------------------
  // Read buffer
  // ------------------------------------------------------------------
  localparam int BUF_WORDS = 10;          // Card read-in words of a band
  localparam int SLOT_W    = 4;
  localparam logic [SLOT_W-1:0] SLOT_LAST  = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h1; // Read-in words start at 1

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_HALT    = 4'b0000,
    ST_I_HALF  = 4'b0001,
    ST_RST_D   = 4'b0010,
    ST_D_HALF  = 4'b0011,
    ST_RST_I   = 4'b0100,
    ST_RD_XFER = 4'b0101,
    ST_RD_WAIT = 4'b0110
  } seq_state_t;

endpackage

// >>> verification/card_reader_model.sv
// Behavioural card reader: places card fields into the input buffer and
// answers each feed request with a back signal one card cycle later.
// Assumes the sequencer's clock; pins change just after falling edges.
`timescale 1ns/1ps
module card_reader_model
  import seq_pkg::*;
#(
  parameter int CARD_CYC = 40   // Card cycle, far shorter than a real reader
) (
  // Clock and feed request
  input  wire logic                ref_clk_i,
  input  wire logic                feed_req_i,
  // Reader pins
  output logic                     stb_o,
  output logic [SLOT_W-1:0]        idx_o,
  output logic [WORD_W-1:0]        word_o,
  output logic                     punch_o,
  output logic                     back_o
);
  initial begin
    stb_o   = 1'b0;
    idx_o   = 4'h0;
    word_o  = 40'h00_0000_0000;
    punch_o = 1'b0;
    back_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // Card past the second station
  // ----------------------------------------------------------------
  // Field k goes to buffer word k; data held well around the strobe
  task automatic put_card(input logic [WORD_W-1:0] base, input int n, input logic p);
    for (int k = 0; k < n; k++) begin
      word_o  = base + 40'(k);
      idx_o   = 4'(k);
      punch_o = p;
      repeat (4) @(negedge ref_clk_i);
      stb_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      stb_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      word_o = ~word_o;  // Released lines must not keep the old field
    end
  endtask

  // One card cycle per feed request before the back signal
  always @(posedge ref_clk_i) begin
    if (feed_req_i === 1'b1) begin
      repeat (CARD_CYC) @(negedge ref_clk_i);
      back_o = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      back_o = 1'b0;
    end
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the instruction sequence controller.
// Assumes a drum model here, the card reader model beside it, keys held
// long enough to pass the pin synchronisers.
`timescale 1ns/1ps
module tb_top;
  import seq_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic run_mode_i = 1'b1;
  logic reset_key_i = 1'b0;
  logic transfer_key_i = 1'b0;
  logic start_key_i = 1'b0;
  logic stor_word_pass_i = 1'b0;
  logic [WORD_W-1:0] entry_sw_i = 40'h00_0000_0000;
  logic [WORD_W-1:0] stor_rd_data_i = 40'h00_0000_0000;
  logic [ADDR_W-1:0] addr_sw_i = 16'h0000;
  logic card_word_stb_i, card_load_punch_i, reader_back_i, feed_req_o, stor_readin_o;
  logic stor_wr_en_o, halted_o;
  logic [SLOT_W-1:0] card_word_idx_i, stor_slot_o;
  logic [WORD_W-1:0] card_word_i, stor_wr_data_o, prog_o, dist_o;
  logic [ADDR_W-1:0] stor_addr_o;
  logic [OP_W-1:0] op_o;
  logic [WORD_W-1:0] mem [0:65535];
  logic [WORD_W-1:0] rd_in [0:15];
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  instruction_sequence_control dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .entry_sw_i(entry_sw_i), .addr_sw_i(addr_sw_i), .run_mode_i(run_mode_i),
    .reset_key_i(reset_key_i), .transfer_key_i(transfer_key_i), .start_key_i(start_key_i),
    .card_word_stb_i(card_word_stb_i), .card_word_idx_i(card_word_idx_i),
    .card_word_i(card_word_i), .card_load_punch_i(card_load_punch_i),
    .reader_back_i(reader_back_i), .feed_req_o(feed_req_o),
    .stor_word_pass_i(stor_word_pass_i), .stor_rd_data_i(stor_rd_data_i),
    .stor_addr_o(stor_addr_o), .stor_readin_o(stor_readin_o), .stor_slot_o(stor_slot_o),
    .stor_wr_en_o(stor_wr_en_o), .stor_wr_data_o(stor_wr_data_o), .prog_o(prog_o),
    .dist_o(dist_o), .op_o(op_o), .halted_o(halted_o));

  card_reader_model reader (.ref_clk_i(ref_clk_i), .feed_req_i(feed_req_o),
    .stb_o(card_word_stb_i), .idx_o(card_word_idx_i), .word_o(card_word_i),
    .punch_o(card_load_punch_i), .back_o(reader_back_i));

  // ----------------------------------------------------------------
  // Drum model: a word passes every fourth word time
  // ----------------------------------------------------------------
  always @(negedge ref_clk_i) begin
    cyc <= cyc + 1;
    stor_word_pass_i <= (cyc % 4 == 0);
    stor_rd_data_i <= mem[stor_addr_o];
  end
  // Read-in words are kept apart so band arithmetic stays out of the model
  always @(posedge ref_clk_i) begin
    if (stor_wr_en_o === 1'b1 && stor_readin_o === 1'b1) rd_in[stor_slot_o] = stor_wr_data_o;
    else if (stor_wr_en_o === 1'b1) mem[stor_addr_o] = stor_wr_data_o;
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Key 0 is computer reset, key 1 is transfer
  task automatic press(input int k);
    for (int i = 0; i < 16; i++) begin
      reset_key_i = (k == 0) && (i < 8);
      transfer_key_i = (k == 1) && (i < 8);
      @(negedge ref_clk_i);
    end
  endtask

  // Program start, then wait under a bound for the next halt
  task automatic run();
    logic left = 1'b0;
    start_key_i = 1'b1;
    for (int i = 0; i < 3000 && !(left && halted_o === 1'b1); i++) begin
      @(negedge ref_clk_i);
      if (i == 8) start_key_i = 1'b0;
      if (halted_o === 1'b0) left = 1'b1;
    end
    chk({39'h0, left & halted_o}, 40'h1);
    start_key_i = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_noop_from_switches();
    mem[16'h0101] = 40'h01_0000_0000;
    entry_sw_i = 40'h00_0000_0101;
    press(0);
    chk(stor_addr_o, 40'h8000);
    run();
    chk(prog_o, 40'h01_0000_0000);
    chk(stor_addr_o, 40'h0000);
    chk(op_o, OP_STOP);
    repeat (40) @(negedge ref_clk_i);
    chk(halted_o, 40'h1);
    // Frozen enable: a start press made while it is low must go unseen
    ce_i = 1'b0;
    start_key_i = 1'b1;
    repeat (12) @(negedge ref_clk_i);
    start_key_i = 1'b0;
    ce_i = 1'b1;
    repeat (12) @(negedge ref_clk_i);
    chk(halted_o, 40'h1);
  endtask

  task automatic t_transfer_load_store();
    mem[16'h0300] = 40'h12_3456_7890;
    mem[16'h0200] = 40'h60_0300_0201;
    mem[16'h0201] = 40'h24_0400_0202;
    mem[16'h0202] = 40'h01_0000_0000;
    addr_sw_i = 16'h0200;
    press(1);
    chk(stor_addr_o, 40'h0200);
    run();
    chk(dist_o, 40'h12_3456_7890);
    chk(mem[16'h0400], 40'h12_3456_7890);
    chk(prog_o, 40'h01_0000_0000);
  endtask

  // Read op: exp_addr tells load redirection from a normal restart
  task automatic t_read(input logic p, input int n, input logic [ADDR_W-1:0] exp_addr);
    mem[16'h0001] = 40'h01_0777_0000;
    mem[16'h0058] = 40'h01_0666_0000;
    reader.put_card(40'h55_0000_0000 + {39'h0, p}, n, p);
    entry_sw_i = 40'h70_0001_0058;
    press(0);
    run();
    chk(rd_in[1], 40'h55_0000_0000 + {39'h0, p});
    chk(rd_in[4], 40'h55_0000_0003 + {39'h0, p});
    chk(rd_in[10], (n == 10) ? 40'h55_0000_0009 + {39'h0, p} : WORD_BLANK);
    chk(stor_addr_o, exp_addr);
  endtask

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    // A few hundred clocks suffice; this leaves ample slack for the card cycles
    #400_000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    t_noop_from_switches();
    t_transfer_load_store();
    t_read(1'b1, 10, 16'h0777);
    t_read(1'b0, 4, 16'h0666);
    report_and_stop();
  end
endmodule
